/* design/psl_defines.vh */
// Field positions, latch codes and reset values of the serial latch bank
`ifndef PSL_DEFINES_VH
`define PSL_DEFINES_VH

// ----------------------------------------------------------------------
// Input word
// ----------------------------------------------------------------------
`define PSL_WORD_W        24
`define PSL_SEL_HI        1
`define PSL_SEL_LO        0
`define PSL_SEL_CONTROL   2'h0
`define PSL_SEL_REFDIV    2'h1
`define PSL_SEL_FBDIV     2'h2
`define PSL_SEL_TEST      2'h3

// ----------------------------------------------------------------------
// Control latch fields
// ----------------------------------------------------------------------
`define PSL_C_CORE_HI     3
`define PSL_C_CORE_LO     2
`define PSL_C_CNT_RST     4
`define PSL_C_MUX_HI      7
`define PSL_C_MUX_LO      5
`define PSL_C_POLARITY    8
`define PSL_C_TRISTATE    9
`define PSL_C_GAIN        10
`define PSL_C_MUTE        11
`define PSL_C_OPWR_HI     13
`define PSL_C_OPWR_LO     12
`define PSL_C_CUR_A_HI    16
`define PSL_C_CUR_A_LO    14
`define PSL_C_CUR_B_HI    19
`define PSL_C_CUR_B_LO    17
`define PSL_C_PDN_HI      21
`define PSL_C_PDN_LO      20
`define PSL_C_PRE_HI      23
`define PSL_C_PRE_LO      22

// ----------------------------------------------------------------------
// Feedback divider latch fields
// ----------------------------------------------------------------------
`define PSL_N_SWAL_HI     6
`define PSL_N_SWAL_LO     2
`define PSL_N_MAIN_HI     20
`define PSL_N_MAIN_LO     8
`define PSL_N_GAIN        21
`define PSL_N_DIV2        22
`define PSL_N_DIV2_SEL    23

// ----------------------------------------------------------------------
// Reference divider latch fields
// ----------------------------------------------------------------------
`define PSL_R_REF_HI      15
`define PSL_R_REF_LO      2
`define PSL_R_ABL_HI      17
`define PSL_R_ABL_LO      16
`define PSL_R_LOCK_PREC   18
`define PSL_R_TEST_EN     19
`define PSL_R_BSC_HI      21
`define PSL_R_BSC_LO      20

// ----------------------------------------------------------------------
// Prescaler values, limits, lock counts, reset values
// ----------------------------------------------------------------------
`define PSL_PRE_8         6'h08
`define PSL_PRE_16        6'h10
`define PSL_PRE_32        6'h20
`define PSL_MAIN_MIN      13'h0003
`define PSL_REF_MIN       14'h0001
`define PSL_LOCK_FINE     3'h5
`define PSL_LOCK_COARSE   3'h3
`define PSL_CTRL_RST      24'h000000
`define PSL_FB_RST        24'h000000
`define PSL_REF_RST       24'h000000
`define PSL_TOTAL_W       19

`endif

/* design/psl_latch_bank.v */
// Serially loaded configuration latch bank of an integer-N synthesizer
//
// Operation
// [R01] Setting A from low current bits
// [R02] Mute outputs until lock when enabled
// [R03] Gain bit picks setting B else A
// [R04] Tri-state bit floats the charge pump
// [R05] Polarity bit: 1 positive, 0 negative
// [R06] Counter reset bit holds all counters
// [R07] Two bits select core power level
// [R08] Select 10 feedback, 01 reference latch
// [R09] Swallow count is 5 bits, 0..31
// [R10] Host writes feedback spare bit zero
// [R11] Main count 13 bits, valid 3..8191
// [R12] Total divide is P times B plus A
// [R13] Gain follows latest write, either latch
// [R14] Divide-by-two output enable bit
// [R15] Divided output feeds prescaler when set
// [R16] Reference divide 14 bits, 1..16383
// [R17] Lock after five or three good cycles
// [R18] Test latch ignored while test bit clear
// [R19] Band-select clock from reference, optional divider
// [R20] Host writes reference spare bits zero
// [R21] Host writes reference, control, feedback order
// [R22] Shift on clock rise, transfer on strobe
// [R23] Select 00 writes control latch
// [R24] Prescaler bits set prescaler value
// [R25] Host shifts words MSB first
`timescale 1ns/1ps
`include "psl_defines.vh"

module psl_latch_bank (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_b,
  // Three-wire serial link
  input  wire        ser_clk,
  input  wire        ser_data,
  input  wire        word_load_strobe,
  // Loop status from the analog side
  input  wire        ref_count_tick,
  input  wire        phase_err_small,
  // Charge pump
  output wire [2:0]  pump_current_sel,
  output wire        pump_gain,
  output wire        pump_tristate,
  output wire        detector_polarity,
  // Counters
  output wire        counter_reset,
  output wire [5:0]  prescaler_value,
  output wire [4:0]  swallow_count,
  output wire [12:0] main_count,
  output wire        main_count_valid,
  output reg  [18:0] total_divide,
  output wire [13:0] ref_divide,
  output wire        ref_divide_valid,
  output wire [1:0]  backlash_width,
  // Oscillator and output stage
  output wire [1:0]  core_power,
  output wire [1:0]  output_power,
  output wire [1:0]  power_down_mode,
  output wire [2:0]  mux_select,
  output wire        out_div2_en,
  output wire        prescaler_from_div2,
  output wire        rf_output_on,
  // Lock detect and band select
  output wire        lock_detect,
  output wire        band_clk_en,
  // Test latch
  output wire        factory_test_active,
  output wire [23:0] test_word
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg  [23:0] shift_r;
  reg  [23:0] ctrl_r;
  reg  [23:0] fb_r;
  reg  [23:0] ref_r;
  reg  [23:0] test_r;
  reg         gain_r;
  reg         sclk_d_r;
  reg         strobe_d_r;
  reg  [2:0]  good_cnt_r;
  reg         lock_r;
  reg  [3:0]  bsc_cnt_r;
  reg         bsc_en_r;

  wire        sclk_rise;
  wire        strobe_rise;
  wire [1:0]  sel;
  wire [2:0]  lock_target;
  wire [3:0]  bsc_limit;
  wire [1:0]  bsc_code;

  // --------------------------------------------------------------------
  // Link edge detection
  // --------------------------------------------------------------------
  // Link pins arrive synchronous to mclk, so one stage finds each edge
  assign sclk_rise   = ser_clk & ~sclk_d_r;
  assign strobe_rise = word_load_strobe & ~strobe_d_r;

  always @(posedge mclk) begin
    if (!rst_b) begin
      sclk_d_r   <= 1'b0;
      strobe_d_r <= 1'b0;
    end else begin
      sclk_d_r   <= ser_clk;
      strobe_d_r <= word_load_strobe;
    end
  end

  // --------------------------------------------------------------------
  // Input shift register
  // --------------------------------------------------------------------
  // New bits enter at the bottom; the last bit shifted lands in bit 0
  always @(posedge mclk) begin
    if (!rst_b) begin
      shift_r <= 24'h000000;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[`PSL_WORD_W-2:0], ser_data}; // [R22] [R25]
    end
  end

  assign sel = shift_r[`PSL_SEL_HI:`PSL_SEL_LO];

  // --------------------------------------------------------------------
  // Latch transfer
  // --------------------------------------------------------------------
  // A clock edge and a strobe edge in one cycle: the strobe takes the
  // word as it stood before that clock edge
  always @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_r <= `PSL_CTRL_RST;
      fb_r   <= `PSL_FB_RST;
      ref_r  <= `PSL_REF_RST;
      test_r <= 24'h000000;
      gain_r <= 1'b0;
    end else if (strobe_rise) begin // [R22]
      case (sel)
        `PSL_SEL_CONTROL: begin
          ctrl_r <= shift_r; // [R23]
          gain_r <= shift_r[`PSL_C_GAIN]; // [R13]
        end
        `PSL_SEL_FBDIV: begin
          fb_r   <= shift_r; // [R08]
          gain_r <= shift_r[`PSL_N_GAIN]; // [R13]
        end
        `PSL_SEL_REFDIV: begin
          ref_r  <= shift_r; // [R08]
        end
        `PSL_SEL_TEST: begin
          test_r <= shift_r;
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Control latch decode
  // --------------------------------------------------------------------
  assign pump_gain         = gain_r;
  assign pump_current_sel  = gain_r ?
                             ctrl_r[`PSL_C_CUR_B_HI:`PSL_C_CUR_B_LO] :
                             ctrl_r[`PSL_C_CUR_A_HI:`PSL_C_CUR_A_LO];
                             // [R01] [R03]
  assign pump_tristate     = ctrl_r[`PSL_C_TRISTATE]; // [R04]
  assign detector_polarity = ctrl_r[`PSL_C_POLARITY]; // [R05]
  assign counter_reset     = ctrl_r[`PSL_C_CNT_RST]; // [R06]
  assign core_power        = ctrl_r[`PSL_C_CORE_HI:`PSL_C_CORE_LO]; // [R07]
  assign output_power      = ctrl_r[`PSL_C_OPWR_HI:`PSL_C_OPWR_LO];
  assign power_down_mode   = ctrl_r[`PSL_C_PDN_HI:`PSL_C_PDN_LO];
  assign mux_select        = ctrl_r[`PSL_C_MUX_HI:`PSL_C_MUX_LO];

  // Prescaler code 11 repeats the largest modulus
  assign prescaler_value =
    (ctrl_r[`PSL_C_PRE_HI:`PSL_C_PRE_LO] == 2'h0) ? `PSL_PRE_8  :
    (ctrl_r[`PSL_C_PRE_HI:`PSL_C_PRE_LO] == 2'h1) ? `PSL_PRE_16 :
                                                    `PSL_PRE_32; // [R24]

  // --------------------------------------------------------------------
  // Feedback latch decode
  // --------------------------------------------------------------------
  assign swallow_count       = fb_r[`PSL_N_SWAL_HI:`PSL_N_SWAL_LO]; // [R09]
  assign main_count          = fb_r[`PSL_N_MAIN_HI:`PSL_N_MAIN_LO];
  assign main_count_valid    = (main_count >= `PSL_MAIN_MIN); // [R11]
  assign out_div2_en         = fb_r[`PSL_N_DIV2]; // [R14]
  assign prescaler_from_div2 = fb_r[`PSL_N_DIV2_SEL]; // [R15]

  // Registered so the product path does not reach the outputs directly
  always @(posedge mclk) begin
    if (!rst_b) begin
      total_divide <= 19'h00000;
    end else begin
      total_divide <= {13'h0000, prescaler_value} * {6'h00, main_count}
                    + {14'h0000, swallow_count}; // [R12]
    end
  end

  // --------------------------------------------------------------------
  // Reference latch decode
  // --------------------------------------------------------------------
  assign ref_divide       = ref_r[`PSL_R_REF_HI:`PSL_R_REF_LO];
  assign ref_divide_valid = (ref_divide >= `PSL_REF_MIN); // [R16]
  assign backlash_width   = ref_r[`PSL_R_ABL_HI:`PSL_R_ABL_LO];
  assign lock_target      = ref_r[`PSL_R_LOCK_PREC] ?
                            `PSL_LOCK_FINE : `PSL_LOCK_COARSE; // [R17]

  // Test word reaches nothing unless the test bit is set
  assign factory_test_active = ref_r[`PSL_R_TEST_EN]; // [R18]
  assign test_word = factory_test_active ? test_r : 24'h000000; // [R18]

  // --------------------------------------------------------------------
  // Lock detect
  // --------------------------------------------------------------------
  // One reference cycle with a large error drops lock at once
  always @(posedge mclk) begin
    if (!rst_b || counter_reset) begin
      good_cnt_r <= 3'h0; // [R06]
      lock_r     <= 1'b0;
    end else if (ref_count_tick) begin
      if (!phase_err_small) begin
        good_cnt_r <= 3'h0;
        lock_r     <= 1'b0;
      end else if (good_cnt_r < lock_target) begin
        good_cnt_r <= good_cnt_r + 3'h1;
        lock_r     <= (good_cnt_r + 3'h1 == lock_target); // [R17]
      end else begin
        lock_r     <= 1'b1;
      end
    end
  end

  assign lock_detect  = lock_r;
  assign rf_output_on = ~ctrl_r[`PSL_C_MUTE] | lock_r; // [R02]

  // --------------------------------------------------------------------
  // Band-select clock divider
  // --------------------------------------------------------------------
  // Codes 0..3 divide the reference tick by 1, 2, 4 and 8
  assign bsc_code  = ref_r[`PSL_R_BSC_HI:`PSL_R_BSC_LO];
  assign bsc_limit = (4'h1 << bsc_code) - 4'h1;

  always @(posedge mclk) begin
    if (!rst_b || counter_reset) begin
      bsc_cnt_r <= 4'h0; // [R06]
      bsc_en_r  <= 1'b0;
    end else if (ref_count_tick) begin
      if (bsc_cnt_r >= bsc_limit) begin
        bsc_cnt_r <= 4'h0;
        bsc_en_r  <= 1'b1; // [R19]
      end else begin
        bsc_cnt_r <= bsc_cnt_r + 4'h1;
        bsc_en_r  <= 1'b0;
      end
    end else begin
      bsc_en_r <= 1'b0;
    end
  end

  assign band_clk_en = bsc_en_r;

endmodule

/* sim/psl_props.sv */
// Checker of latch bank output relations
`timescale 1ns/1ps
module psl_props (
  // Clock and reset
  input wire        mclk,
  input wire        rst_b,
  // Loop status
  input wire        ref_count_tick,
  input wire        phase_err_small,
  // Watched outputs
  input wire [5:0]  prescaler_value,
  input wire [4:0]  swallow_count,
  input wire [12:0] main_count,
  input wire        main_count_valid,
  input wire [18:0] total_divide,
  input wire [13:0] ref_divide,
  input wire        ref_divide_valid,
  input wire        counter_reset,
  input wire        rf_output_on,
  input wire        lock_detect,
  input wire        band_clk_en,
  input wire        factory_test_active,
  input wire [23:0] test_word
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire [18:0] tot_w = prescaler_value * main_count + swallow_count;
  reg  [2:0]  good_r;
  // Saturates so long lock runs never wrap
  always @(posedge mclk) begin
    if (!rst_b || counter_reset || (ref_count_tick && !phase_err_small))
      good_r <= 3'h0;
    else if (ref_count_tick && good_r != 3'h7)
      good_r <= good_r + 3'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  total_calc_a: assert property ($past(rst_b) |->
    total_divide == $past(tot_w)) else $error("total divide wrong");
  main_valid_a: assert property (
    main_count_valid == (main_count > 2))
    else $error("main valid wrong");
  ref_valid_a: assert property (
    ref_divide_valid == (ref_divide != 0))
    else $error("ref valid wrong");
  pre_legal_a: assert property (
    prescaler_value inside {8, 16, 32})
    else $error("prescaler illegal");
  mute_lock_a: assert property (lock_detect |-> rf_output_on)
    else $error("output muted while locked");
  lock_count_a: assert property (
    $rose(lock_detect) |-> good_r > 2)
    else $error("lock too early");
  bad_tick_a: assert property (
    ref_count_tick && !phase_err_small |=> !lock_detect)
    else $error("lock kept after bad tick");
  cnt_hold_a: assert property (
    counter_reset ##1 counter_reset |-> !lock_detect)
    else $error("lock during counter reset");
  band_tick_a: assert property (
    band_clk_en |-> $past(ref_count_tick))
    else $error("band clock without tick");
  test_off_a: assert property (
    !factory_test_active |-> test_word == 0)
    else $error("test word leaks");
  cover property ($rose(lock_detect));
  cover property (band_clk_en);
  cover property (factory_test_active);
  cover property (counter_reset ##1 counter_reset);
endmodule

/* sim/psl_host.sv */
// Host model driving the three-wire serial link
`timescale 1ns/1ps
module psl_host (
  // Clock
  input  wire mclk,
  // Serial link
  output reg  ser_clk,
  output reg  ser_data,
  output reg  word_load_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    word_load_strobe = 1'b0;
  end
  // Hold is half period in mclk cycles; larger is a slow host
  task automatic send(input [23:0] w, input integer hold);
    integer i;
    begin
      for (i = 23; i >= 0; i = i - 1) begin
        ser_data <= w[i];
        repeat (hold) @(posedge mclk);
        ser_clk <= 1'b1;
        repeat (hold) @(posedge mclk);
        ser_clk <= 1'b0;
      end
      // Released data line must not look like the last bit
      ser_data <= ~w[0];
      @(posedge mclk);
      word_load_strobe <= 1'b1;
      @(posedge mclk);
      word_load_strobe <= 1'b0;
      @(posedge mclk);
    end
  endtask
endmodule

/* sim/tb_psl_latch_bank.sv */
// Self-checking bench of the serial latch bank
`timescale 1ns/1ps
module tb_psl_latch_bank;
  reg         mclk, rst_b, ref_count_tick, phase_err_small;
  wire        ser_clk, ser_data, word_load_strobe;
  wire [2:0]  pump_current_sel, mux_select;
  wire        pump_gain, pump_tristate, detector_polarity, counter_reset;
  wire [5:0]  prescaler_value;
  wire [4:0]  swallow_count;
  wire [12:0] main_count;
  wire        main_count_valid, ref_divide_valid, out_div2_en;
  wire [18:0] total_divide;
  wire [13:0] ref_divide;
  wire [1:0]  backlash_width, core_power, output_power, power_down_mode;
  wire        prescaler_from_div2, rf_output_on, lock_detect;
  wire        band_clk_en, factory_test_active;
  wire [23:0] test_word;
  reg  [23:0] ctrl_m, fb_m, ref_m, test_m;
  reg         gain_m;
  integer     failures, checks_done, bcnt, n;
  psl_latch_bank psl_latch_bank_inst (.*);
  psl_host psl_host_inst (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task final_report;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task ck(input ok, input string msg);
    begin
      checks_done = checks_done + 1;
      if (ok !== 1'b1) begin
        failures = failures + 1;
        $display("unexpected at %0t ns: %s", $time, msg);
      end
    end
  endtask
  function [23:0] rw(input [1:0] sel);
    reg [23:0] w;
    begin
      w = $urandom;
      if (sel == 2'h1) w = w & 24'h37FFFF;
      if (sel == 2'h2) w = w & 24'hFFFF7F;
      rw = {w[23:2], sel};
    end
  endfunction
  task chk;
    reg [5:0] p;
    reg [2:0] e3;
    begin
      p = ctrl_m[23] ? 6'h20 : (ctrl_m[22] ? 6'h10 : 6'h08);
      e3 = gain_m ? ctrl_m[19:17] : ctrl_m[16:14];
      ck(pump_current_sel === e3, "current");
      ck(pump_gain === gain_m, "gain");
      ck(pump_tristate === ctrl_m[9], "tristate");
      ck(detector_polarity === ctrl_m[8], "polarity");
      ck(counter_reset === ctrl_m[4], "counter reset");
      ck(core_power === ctrl_m[3:2], "core power");
      ck(output_power === ctrl_m[13:12], "output power");
      ck(power_down_mode === ctrl_m[21:20], "power down");
      ck(mux_select === ctrl_m[7:5], "mux select");
      ck(prescaler_value === p, "prescaler");
      ck(swallow_count === fb_m[6:2], "swallow");
      ck(main_count === fb_m[20:8], "main");
      ck(main_count_valid === (fb_m[20:8] > 2), "main valid");
      ck(total_divide === p * fb_m[20:8] + fb_m[6:2], "total");
      ck(out_div2_en === fb_m[22], "div2");
      ck(prescaler_from_div2 === fb_m[23], "div2 select");
      ck(ref_divide === ref_m[15:2], "ref");
      ck(ref_divide_valid === (ref_m[15:2] != 0), "ref valid");
      ck(backlash_width === ref_m[17:16], "backlash");
      ck(factory_test_active === ref_m[19], "test active");
      ck(test_word === (ref_m[19] ? test_m : 24'h0), "test word");
    end
  endtask
  task wr(input [23:0] w);
    begin
      @(posedge mclk);
      psl_host_inst.send(w, 1 + $urandom % 3);
      case (w[1:0])
        2'h0: begin
          ctrl_m = w;
          gain_m = w[10];
        end
        2'h1: ref_m = w;
        2'h2: begin
          fb_m = w;
          gain_m = w[21];
        end
        default: test_m = w;
      endcase
      @(posedge mclk);
      #1;
      chk;
    end
  endtask
  task ticks(input integer cnt, input bad);
    integer i;
    begin
      for (i = 0; i < cnt; i = i + 1) begin
        @(posedge mclk);
        ref_count_tick <= 1'b1;
        phase_err_small <= !bad;
        @(posedge mclk);
        ref_count_tick <= 1'b0;
        #1;
        if (band_clk_en === 1'b1) bcnt = bcnt + 1;
      end
    end
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, ref_count_tick, phase_err_small, gain_m} = 4'h0;
    {ctrl_m, fb_m, ref_m, test_m} = 96'h0;
    {failures, checks_done, bcnt} = 0;
    void'($urandom(21));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    #1;
    chk;
    ck(rf_output_on === 1'b1 && lock_detect === 1'b0, "reset");
    $display("test reset done");
    wr(rw(2'h1));
    wr(rw(2'h0));
    wr(rw(2'h2));
    wr({3'h0, 13'h0002, 1'b0, 5'h1F, 2'h2});
    wr({3'h0, 13'h0003, 1'b0, 5'h00, 2'h2});
    wr({2'h3, 22'h0});
    wr({3'h0, 13'h1FFF, 1'b0, 5'h1F, 2'h2});
    wr({8'h00, 14'h0000, 2'h1});
    wr({8'h00, 14'h3FFF, 2'h1});
    $display("test bounds done");
    wr(rw(2'h3));
    wr(ref_m | 24'h080000);
    wr(ref_m & 24'h37FFFF);
    $display("test latch done");
    wr((rw(2'h0) & 24'h3FFFEF) | 24'h000800);
    for (n = 0; n < 2; n = n + 1) begin
      wr((rw(2'h1) & 24'hFBFFFF) | (n << 18));
      ticks(n ? 4 : 2, 1'b0);
      ck(lock_detect === 1'b0, "early");
      ck(rf_output_on === 1'b0, "muted");
      ticks(1, 1'b0);
      ck(lock_detect === 1'b1, "lock");
      ck(rf_output_on === 1'b1, "unmuted");
      ticks(1, 1'b1);
      ck(lock_detect === 1'b0, "unlock");
      ck(rf_output_on === 1'b0, "muted again");
    end
    wr(ctrl_m | 24'h000010);
    ticks(6, 1'b0);
    ck(lock_detect === 1'b0, "counter reset lock");
    wr(ctrl_m & 24'hFFFFEF);
    for (n = 0; n < 4; n = n + 1) begin
      wr((rw(2'h1) & 24'hCFFFFF) | (n << 20));
      bcnt = 0;
      ticks(8, 1'b0);
      ck(bcnt == (8 >> n), "band clock");
    end
    $display("test lock done");
    repeat (30) wr(rw(2'($urandom_range(3, 0))));
    $display("test random done");
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    {ctrl_m, fb_m, ref_m, test_m} = 96'h0;
    gain_m = 1'b0;
    @(posedge mclk);
    #1;
    chk;
    ck(rf_output_on === 1'b1 && lock_detect === 1'b0, "rerun");
    ck(band_clk_en === 1'b0, "band after reset");
    $display("test second reset done");
    final_report;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    failures = failures + 1;
    final_report;
  end
endmodule
bind psl_latch_bank psl_props psl_props_inst (.*);
